// >>> dv/sac_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the serial port: shift clock, cascade feed and capture
module sac_host_model (
	// Serial pins
	input  wire logic serial_data_out_i,
	output logic      sclk_o,
	output logic      cascade_o,
	// High holds the frame idle while the word loads
	output logic      gap_o
);
	// Shift clock idles high; outside frames it runs only in pulses, with the frame held off
	initial begin
		sclk_o    = 1'b1;
		cascade_o = 1'b0;
		gap_o     = 1'b0;
	end

	// Idle pulses with the frame held off, 15 ns period
	task automatic pulses(input int n);
		gap_o = 1'b1;
		repeat (n) begin
			#7.5 sclk_o = 1'b0;
			#7.5 sclk_o = 1'b1;
		end
		#20 gap_o = 1'b0;
	endtask

	// Load, then clock n bits out; cascade word fed MSB first
	task automatic read(input int n, input logic [15:0] casc,
		output logic [31:0] q);
		int i;
		q = '0;
		pulses(6);
		#40;
		for (i = 0; i < n; i++) begin
			// Cascade changes after a rise, settled for the fall
			cascade_o = casc[15 - (i & 15)];
			#7.5 sclk_o = 1'b0;
			// Sample on the falling edge, data moved on the rise
			q = {q[30:0], serial_data_out_i};
			#7.5 sclk_o = 1'b1;
		end
		// Released line shows the inverse of its last value
		cascade_o = ~cascade_o;
	endtask
endmodule
`default_nettype wire

// >>> dv/sac_top_test.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the conversion control and output port
module sac_top_test;
	logic                       clk;         // Control clock
	logic                       rst_n;       // Power-on reset
	logic                       start_n;     // Conversion start
	logic                       pd;          // Shutdown request
	logic                       rpin;        // Pin reset
	logic [4:0]                 pins;        // Read pins from bench
	logic [4:0]                 dpins;       // Read pins at the block
	logic [15:0]                code;        // Analog code
	logic                       busy;        // Converting
	logic                       nap;         // Nap state
	logic                       shut;        // Shutdown state
	logic [15:0]                bus;         // Parallel data
	logic [15:0]                oe;          // Parallel enables
	logic                       sdo;         // Serial data
	logic                       sdo_oe;      // Serial enable
	logic                       sclk;        // Shift clock
	logic                       casc;        // Cascade input
	logic                       gap;         // Frame hold-off
	int                         compares;    // Comparisons made
	int                         miscompares; // Mismatches seen
	int                         cycles;      // Timeout counter

	// Frame hold-off from the host model folds into read enable
	assign dpins = {pins[4], pins[3] | gap, pins[2:0]};

	sac_top dut (
		.clk_i                (clk),
		.rst_n_i              (rst_n),
		.sclk_i               (sclk),
		.conv_start_n_i       (start_n),
		.power_down_in_i      (pd),
		.reset_pin_i          (rpin),
		.pins_i               (sac_pkg::sac_pins_t'(dpins)),
		.cascade_data_in_i    (casc),
		.sample_code_i        (code),
		.busy_o               (busy),
		.nap_o                (nap),
		.shutdown_o           (shut),
		.data_out_bus_o       (bus),
		.data_out_bus_oe_o    (oe),
		.serial_data_out_o    (sdo),
		.serial_data_out_oe_o (sdo_oe)
	);

	sac_host_model m (
		.serial_data_out_i (sdo),
		.sclk_o            (sclk),
		.cascade_o         (casc),
		.gap_o             (gap)
	);

	// 100 MHz control clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			conclude();
		end
	end

	// Verdict and end of run
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compare one value
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// Word as it should leave the block
	function automatic logic [15:0] word(input logic [15:0] c,
		input logic fmt, input logic swap);
		logic [15:0] w;
		w = fmt ? c : {~c[15], c[14:0]};
		return swap ? {w[7:0], w[15:8]} : w;
	endfunction

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Start edge; a short low is 20 ns, inside the 40 ns allowance
	task automatic pulse(input logic low);
		start_n = 1'b0;
		idle(2);
		if (!low)
			start_n = 1'b1;
	endtask

	// One conversion, optionally with a second edge while busy
	task automatic conv(input logic [15:0] c, input logic low,
		input logic twice);
		int n;
		code = c;
		pulse(low);
		n = 0;
		while (busy !== 1'b1 && n < 10) begin
			idle(1);
			n++;
		end
		check(busy, 1'b1);
		n = 0;
		if (twice) begin
			idle(10);
			pulse(1'b0);
			n = 12;
		end
		while (busy === 1'b1 && n < 100) begin
			idle(1);
			n++;
		end
		check(n, sac_pkg::CONV_CYC);
		// Full acquisition interval before the next request
		idle(sac_pkg::ACQ_CYC);
		check(busy, 1'b0);
	endtask

	// Parallel read in all format and swap settings, then deselects
	task automatic par_read(input logic [15:0] c);
		int k;
		for (k = 0; k < 4; k++) begin
			pins = {1'b0, 1'b0, 1'b0, k[0], k[1]};
			idle(5);
			check(oe, 16'hffff);
			check(bus, word(c, k[1], k[0]));
		end
		pins[4] = 1'b1;
		idle(5);
		check(oe, 16'h0000);
		pins = 5'b01001;
		idle(5);
		check(oe, 16'h0000);
		pins = 5'b11001;
	endtask

	// Quiet outputs after power-on, first result valid
	task automatic s_power_on();
		check({busy, nap, shut, sdo_oe, oe}, 20'h00000);
		conv(16'h8001, 1'b0, 1'b0);
		par_read(16'h8001);
		conv(16'h7ffe, 1'b0, 1'b1);
		par_read(16'h7ffe);
	endtask

	// Nap entered with start low, left after start high
	task automatic s_nap();
		conv(16'h1234, 1'b1, 1'b0);
		check(nap, 1'b1);
		start_n = 1'b1;
		idle(25);
		check(nap, 1'b0);
		conv(16'h4321, 1'b0, 1'b0);
		par_read(16'h4321);
	endtask

	// Shutdown requested mid-conversion, then a refused start
	task automatic s_shutdown();
		code = 16'h00ff;
		pulse(1'b0);
		idle(20);
		// Mid-conversion request, so no read is owed first
		pd = 1'b1;
		idle(20);
		check({busy, shut}, 2'b10);
		idle(40);
		check({busy, shut}, 2'b01);
		par_read(16'h00ff);
		pulse(1'b0);
		idle(10);
		check(busy, 1'b0);
		pd = 1'b0;
		// No reference to settle here, so a short recovery wait
		idle(10);
		check(shut, 1'b0);
	endtask

	// Pin reset halts a conversion and floats the bus
	task automatic s_reset_pin();
		code = 16'hbeef;
		pulse(1'b0);
		idle(20);
		pins = 5'b00001;
		rpin = 1'b1;
		idle(6);
		check({busy, oe}, 17'h00000);
		pulse(1'b0);
		idle(10);
		check(busy, 1'b0);
		rpin = 1'b0;
		idle(45);
		conv(16'hbeef, 1'b0, 1'b0);
		par_read(16'hbeef);
	endtask

	// Serial read of two chained words in both formats
	task automatic s_serial();
		logic [31:0] q;
		int f;
		for (f = 0; f < 2; f++) begin
			conv(16'ha5c3, 1'b0, 1'b0);
			pins = {1'b0, 1'b0, 1'b1, 1'b0, f[0]};
			m.read(32, 16'h6e19, q);
			idle(1);
			check(q, {word(16'ha5c3, f[0], 1'b0), 16'h6e19});
			check({sdo_oe, oe}, 17'h10000);
			pins = 5'b11001;
			idle(5);
			check(sdo_oe, 1'b0);
		end
	endtask

	initial begin
		rst_n   = 1'b0;
		start_n = 1'b1;
		pd      = 1'b0;
		rpin    = 1'b0;
		code    = 16'h0000;
		pins    = 5'b11001;
		// Shift domain reset needs shift clock edges too
		fork
			m.pulses(4);
			repeat (16) @(negedge clk);
		join
		rst_n = 1'b1;
		idle(30);
		s_power_on();
		s_nap();
		s_shutdown();
		s_reset_pin();
		s_serial();
		conclude();
	end
endmodule
`default_nettype wire

// >>> hdl/sac_pkg.sv
package sac_pkg;

	// Clock rate of the control domain
	localparam int unsigned CLK_MHZ = 100;

	// Word layout
	localparam int unsigned WORD_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned MSB    = 15;

	// Counter width for all timed states
	localparam int unsigned CNT_W = 8;

	// Longest conversion time, rounded down to cycles
	localparam int unsigned CONV_NS = 600;
	localparam logic [CNT_W-1:0] CONV_CYC =
		CNT_W'(CONV_NS * CLK_MHZ / 1000);

	// Acquisition time after pin reset, rounded up to cycles
	localparam int unsigned ACQ_NS = 385;
	localparam logic [CNT_W-1:0] ACQ_CYC =
		CNT_W'((ACQ_NS * CLK_MHZ + 999) / 1000);

	// Power-on initialisation length in cycles
	localparam logic [CNT_W-1:0] POR_CYC = 8'h10;

	// Values after reset
	localparam logic [WORD_W-1:0] RESULT_RST = 16'h0000;

	// Idle levels of synchronised pins, same order as the sync vector
	localparam logic [7:0] PIN_IDLE = 8'h99;

	// Host-side interface pins
	typedef struct packed {
		logic cs_n;     // Chip select, low active
		logic rd_n;     // Read enable, low active
		logic ser_sel;  // serial_parallel_select, high is serial
		logic swap;     // byte_order_swap
		logic fmt;      // output_format_select, high is offset binary
	} sac_pins_t;

	// Converter control states
	typedef enum logic [2:0] {
		ST_POR   = 3'h0,
		ST_ACQ   = 3'h1,
		ST_CONV  = 3'h2,
		ST_NAP   = 3'h3,
		ST_SHUT  = 3'h4,
		ST_RECOV = 3'h5
	} sac_state_t;

endpackage

// >>> hdl/sac_shift.sv
`timescale 1ns/100ps
`default_nettype none
module sac_shift (
	// Shift clock domain
	input  wire logic                       sclk_i,
	input  wire logic                       rst_n_i,
	// Frame and new-word notice
	input  wire logic                       frame_n_i,
	input  wire logic                       tgl_i,
	// Quasi-static result word from the control domain
	input  wire logic [sac_pkg::WORD_W-1:0] word_i,
	// Serial pins
	input  wire logic                       cascade_i,
	output logic                            sdo_o
);

	logic [sac_pkg::WORD_W-1:0] hold_reg;   // Copy of latest word
	logic [sac_pkg::WORD_W-1:0] sreg_reg;   // Output shifter
	logic                       seen_reg;   // Last toggle taken
	logic                       casc_reg;   // Cascade bit, falling edge
	logic                       fresh_reg;  // First edge after reset
	logic                       fresh_next;
	logic [sac_pkg::WORD_W-1:0] hold_next;
	logic [sac_pkg::WORD_W-1:0] sreg_next;
	logic                       seen_next;

	// Load while idle, shift while framed
	always_comb begin
		seen_next  = tgl_i;
		fresh_next = 1'b0;
		// Reload after reset too, whatever the toggle's parity
		hold_next = ((tgl_i != seen_reg) || fresh_reg) ? word_i : hold_reg;
		if (!frame_n_i) begin
			// Change on rising edge, cascade fills behind
			sreg_next = {sreg_reg[sac_pkg::MSB-1:0], casc_reg}; // R18 R21
		end else begin
			sreg_next = hold_reg;
		end
	end

	// Rising-edge registers
	always_ff @(posedge sclk_i) begin
		if (!rst_n_i) begin
			hold_reg <= sac_pkg::RESULT_RST;
			sreg_reg <= sac_pkg::RESULT_RST;
			seen_reg <= 1'b0;
			fresh_reg <= 1'b1;
		end else begin
			hold_reg <= hold_next;
			sreg_reg <= sreg_next;
			seen_reg <= seen_next;
			fresh_reg <= fresh_next;
		end
	end

	// Cascade input captured on falling edge
	always_ff @(negedge sclk_i) begin
		casc_reg <= cascade_i; // R21
	end

	assign sdo_o = sreg_reg[sac_pkg::MSB]; // R17

	// Each framed rising edge advances one bit
	a_shift_step : assert property (@(posedge sclk_i) disable iff (!rst_n_i)
		(!frame_n_i && $past(!frame_n_i)) |=>
		sdo_o == $past(sreg_reg[sac_pkg::MSB-1], 1)) // R18
		else $error("serial output did not advance by one bit");

endmodule
`default_nettype wire

// >>> hdl/sac_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sac_sync #(
	parameter int unsigned   W   = 1,
	parameter logic [W-1:0]  RST = '0
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_reg;  // First stage, read only by second
	logic [W-1:0] q_reg;     // Second stage
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	// Next values
	always_comb begin
		meta_next = d_i;
		q_next    = meta_reg;
	end

	// Two-stage synchroniser
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_reg <= RST;
			q_reg    <= RST;
		end else begin
			meta_reg <= meta_next;
			q_reg    <= q_next;
		end
	end

	assign q_o = q_reg;

endmodule
`default_nettype wire

// >>> hdl/sac_top.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: Power-on reset makes first conversion valid
// R2: Start held low after conversion enters nap
// R3: Host holds start high 250ns leaving nap
// R4: Power down high ignores every conversion request
// R5: Shutdown during conversion waits; result stays readable
// R6: Host reads data before asserting power down
// R7: Host waits about 5ms after power down
// R8: Falling start edge begins a conversion
// R9: Start edges ignored while converting
// R10: Busy high exactly while converting
// R11: Host returns start high within 40ns
// R12: Internal timer ends conversion within 600ns
// R13: Host allows up to 385ns acquisition
// R14: Select or read high floats data outputs
// R15: Parallel mode drives full 16-bit word
// R16: Byte swap exchanges high and low bytes
// R17: Serial mode shifts result on host clock
// R18: Data changes rising, MSB held until then
// R19: Host runs shift clock at 40MHz minimum
// R20: Serial mode floats unused parallel outputs
// R21: Cascade input shifts behind local result
// R22: Format low inverts MSB for two's complement
// R23: Reset pin halts, floats bus, ignores requests
module sac_top (
	// Control clock and power-on reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	// Host shift clock
	input  wire logic                       sclk_i,
	// Conversion control pins
	input  wire logic                       conv_start_n_i,
	input  wire logic                       power_down_in_i,
	input  wire logic                       reset_pin_i,
	// Read interface pins
	input  wire sac_pkg::sac_pins_t         pins_i,
	input  wire logic                       cascade_data_in_i,
	// Code from the analog comparator array
	input  wire logic [sac_pkg::WORD_W-1:0] sample_code_i,
	// Status
	output logic                            busy_o,
	output logic                            nap_o,
	output logic                            shutdown_o,
	// Parallel bus
	output logic [sac_pkg::WORD_W-1:0]      data_out_bus_o,
	output logic [sac_pkg::WORD_W-1:0]      data_out_bus_oe_o,
	// Serial output
	output logic                            serial_data_out_o,
	output logic                            serial_data_out_oe_o
);

	// Synchronised pins
	logic [7:0]                 pin_s;      // Sync vector output
	logic                       start_s;    // conv_start_n level
	logic                       pd_s;       // power_down_in level
	logic                       rpin_s;     // Reset pin level
	sac_pkg::sac_pins_t         pins_s;     // Interface pins

	// Conversion control state
	sac_pkg::sac_state_t        state_reg;
	sac_pkg::sac_state_t        state_next;
	logic [sac_pkg::CNT_W-1:0]  cnt_reg;    // Timer for timed states
	logic [sac_pkg::CNT_W-1:0]  cnt_next;
	logic                       start_prev_reg; // For edge detection
	logic                       start_prev_next;
	logic [sac_pkg::WORD_W-1:0] result_reg; // Raw offset-binary code
	logic [sac_pkg::WORD_W-1:0] result_next;
	logic                       start_fall; // Falling start edge

	// Output state
	logic [sac_pkg::WORD_W-1:0] word_reg;   // Formatted result
	logic [sac_pkg::WORD_W-1:0] word_next;
	logic [sac_pkg::WORD_W-1:0] bus_reg;
	logic [sac_pkg::WORD_W-1:0] bus_next;
	logic [sac_pkg::WORD_W-1:0] bus_oe_reg;
	logic [sac_pkg::WORD_W-1:0] bus_oe_next;
	logic                       sdo_oe_reg;
	logic                       sdo_oe_next;
	logic                       busy_reg;
	logic                       busy_next;
	logic                       nap_reg;
	logic                       nap_next;
	logic                       shut_reg;
	logic                       shut_next;
	logic                       tgl_reg;    // Flips on each new word
	logic                       tgl_next;
	logic                       frame_par;  // Parallel read active
	logic                       frame_ser;  // Serial read active

	// Shift clock domain signals
	logic [1:0]                 sclk_s;     // Synced reset and toggle
	logic                       frame_n;    // Serial frame, link side
	logic                       sdo;        // Shifter output bit

	// Helper for assertions: busy length
	logic [sac_pkg::CNT_W-1:0]  busy_len_reg;

	// Pin synchroniser for the control domain
	sac_sync #(
		.W   (8),
		.RST (sac_pkg::PIN_IDLE)
	) u_pin_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({conv_start_n_i, power_down_in_i, reset_pin_i, pins_i}),
		.q_o     (pin_s)
	);

	assign {start_s, pd_s, rpin_s, pins_s} = pin_s;
	assign start_fall = start_prev_reg & ~start_s;

	// Conversion sequencer next state
	always_comb begin
		state_next      = state_reg;
		result_next     = result_reg;
		start_prev_next = start_s;
		cnt_next        = (cnt_reg != '0) ? cnt_reg - 8'h01 : cnt_reg;
		if (rpin_s) begin
			// Abort and hold off requests
			state_next = sac_pkg::ST_RECOV; // R23
			cnt_next   = sac_pkg::ACQ_CYC; // R23
		end else begin
			unique case (state_reg)
				sac_pkg::ST_POR: begin
					// Initialise before first conversion
					if (cnt_reg == '0) begin
						state_next = sac_pkg::ST_ACQ; // R1
					end
				end
				sac_pkg::ST_RECOV: begin
					// Acquisition time after pin reset
					if (cnt_reg == '0) begin
						state_next = sac_pkg::ST_ACQ; // R23
					end
				end
				sac_pkg::ST_ACQ: begin
					if (pd_s) begin
						state_next = sac_pkg::ST_SHUT; // R4
					end else if (start_fall) begin
						state_next = sac_pkg::ST_CONV; // R8
						cnt_next   = sac_pkg::CONV_CYC - 8'h01; // R12
					end
				end
				sac_pkg::ST_CONV: begin
					// Edges ignored until the timer ends
					if (cnt_reg == '0) begin // R9
						result_next = sample_code_i;
						if (pd_s) begin
							state_next = sac_pkg::ST_SHUT; // R5
						end else if (!start_s) begin
							state_next = sac_pkg::ST_NAP; // R2
						end else begin
							state_next = sac_pkg::ST_ACQ;
						end
					end
				end
				sac_pkg::ST_NAP: begin
					// Wake on start returning high
					if (pd_s) begin
						state_next = sac_pkg::ST_SHUT; // R4
					end else if (start_s) begin
						state_next = sac_pkg::ST_ACQ; // R2
					end
				end
				sac_pkg::ST_SHUT: begin
					// Requests ignored until power down drops
					if (!pd_s) begin
						state_next = sac_pkg::ST_ACQ; // R4
					end
				end
				default: begin
					state_next = sac_pkg::ST_POR;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg      <= sac_pkg::ST_POR; // R1
			cnt_reg        <= sac_pkg::POR_CYC;
			start_prev_reg <= 1'b1;
			result_reg     <= sac_pkg::RESULT_RST;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			start_prev_reg <= start_prev_next;
			result_reg     <= result_next;
		end
	end

	// Output formatting and pin drive
	always_comb begin
		// Format high keeps offset binary, low flips the MSB
		word_next = {result_reg[sac_pkg::MSB] ^ ~pins_s.fmt,
			result_reg[sac_pkg::MSB-1:0]}; // R22
		frame_par = ~pins_s.cs_n & ~pins_s.rd_n & ~pins_s.ser_sel
			& ~rpin_s;
		frame_ser = ~pins_s.cs_n & ~pins_s.rd_n & pins_s.ser_sel
			& ~rpin_s;
		if (pins_s.swap) begin
			bus_next = {word_reg[sac_pkg::BYTE_W-1:0],
				word_reg[sac_pkg::MSB:sac_pkg::BYTE_W]}; // R16
		end else begin
			bus_next = word_reg; // R16
		end
		bus_oe_next = {sac_pkg::WORD_W{frame_par}}; // R14 R15 R20
		sdo_oe_next = frame_ser; // R14 R17
		busy_next   = (state_next == sac_pkg::ST_CONV); // R10
		nap_next    = (state_next == sac_pkg::ST_NAP);
		shut_next   = (state_next == sac_pkg::ST_SHUT);
		tgl_next    = tgl_reg ^ (word_next != word_reg);
	end

	// Output registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			word_reg   <= sac_pkg::RESULT_RST;
			bus_reg    <= sac_pkg::RESULT_RST;
			bus_oe_reg <= '0;
			sdo_oe_reg <= 1'b0;
			busy_reg   <= 1'b0;
			nap_reg    <= 1'b0;
			shut_reg   <= 1'b0;
			tgl_reg    <= 1'b0;
		end else begin
			word_reg   <= word_next;
			bus_reg    <= bus_next;
			bus_oe_reg <= bus_oe_next;
			sdo_oe_reg <= sdo_oe_next;
			busy_reg   <= busy_next;
			nap_reg    <= nap_next;
			shut_reg   <= shut_next;
			tgl_reg    <= tgl_next;
		end
	end

	// Reset and new-word toggle into the shift clock domain
	sac_sync #(
		.W   (2),
		.RST (2'h0)
	) u_sclk_sync (
		.clk_i   (sclk_i),
		.rst_n_i (1'b1),
		.d_i     ({rst_n_i, tgl_reg}),
		.q_o     (sclk_s)
	);

	// Frame pins are set up by the host against its own clock
	assign frame_n = pins_i.cs_n | pins_i.rd_n | ~pins_i.ser_sel;

	// Serial shifter on the host clock
	sac_shift u_shift (
		.sclk_i    (sclk_i),
		.rst_n_i   (sclk_s[1]),
		.frame_n_i (frame_n),
		.tgl_i     (sclk_s[0]),
		.word_i    (word_reg),
		.cascade_i (cascade_data_in_i),
		.sdo_o     (sdo)
	);

	// Ports from registers
	assign busy_o               = busy_reg;
	assign nap_o                = nap_reg;
	assign shutdown_o           = shut_reg;
	assign data_out_bus_o       = bus_reg;
	assign data_out_bus_oe_o    = bus_oe_reg;
	assign serial_data_out_o    = sdo;
	assign serial_data_out_oe_o = sdo_oe_reg;

	// Busy length counter for checking
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_len_reg <= '0;
		end else if (busy_reg) begin
			busy_len_reg <= busy_len_reg + 8'h01;
		end else begin
			busy_len_reg <= '0;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_por_quiet : assert property ( // R1
		(state_reg == sac_pkg::ST_POR) |=> !busy_o && !nap_o && !shutdown_o)
		else $error("conversion started during power-on init");
	a_nap_entry : assert property ( // R2
		(state_reg == sac_pkg::ST_CONV && cnt_reg == '0 && !rpin_s
			&& !pd_s && !start_s) |=> nap_o && !busy_o)
		else $error("nap not entered with start held low");
	a_shut_ignore : assert property ( // R4
		(shutdown_o && pd_s && !rpin_s) |=> !busy_o ##1 !busy_o)
		else $error("conversion began during shutdown");
	a_shut_finish : assert property ( // R5
		(state_reg == sac_pkg::ST_CONV && cnt_reg == '0 && pd_s
			&& !rpin_s) |=> shutdown_o
			&& result_reg == $past(sample_code_i))
		else $error("shutdown did not keep the final result");
	a_start_conv : assert property ( // R8
		(state_reg == sac_pkg::ST_ACQ && start_fall && !pd_s && !rpin_s)
			|=> busy_o)
		else $error("falling start edge did not begin conversion");
	a_no_restart : assert property ( // R9
		(state_reg == sac_pkg::ST_CONV && cnt_reg != '0 && !rpin_s)
			|=> state_reg == sac_pkg::ST_CONV
			&& cnt_reg == $past(cnt_reg) - 8'h01)
		else $error("conversion restarted while running");
	a_busy_len : assert property ( // R10 R12
		($fell(busy_o) && !$past(rpin_s)) |->
			busy_len_reg == sac_pkg::CONV_CYC)
		else $error("busy length differs from conversion time");
	a_float_idle : assert property ( // R14
		(pins_s.cs_n || pins_s.rd_n) |=>
			data_out_bus_oe_o == '0 && !serial_data_out_oe_o)
		else $error("outputs driven while deselected");
	a_par_word : assert property ( // R15 R16
		(frame_par && !pins_s.swap && $stable(word_reg))
			|=> &data_out_bus_oe_o && data_out_bus_o == $past(word_reg))
		else $error("parallel word not driven in order");
	a_ser_float : assert property ( // R20
		serial_data_out_oe_o |-> data_out_bus_oe_o == '0)
		else $error("parallel pins driven in serial mode");
	a_format : assert property ( // R22
		!pins_s.fmt |=>
			word_reg[sac_pkg::MSB] != $past(result_reg[sac_pkg::MSB]))
		else $error("MSB not inverted for two's complement");
	a_reset_halt : assert property ( // R23
		rpin_s |=> !busy_o && data_out_bus_oe_o == '0
			&& !serial_data_out_oe_o)
		else $error("reset pin did not halt and float");

endmodule
`default_nettype wire
